// File: pkg/sspa_pkg.sv
// sspa_pkg: constants, parameter table and carrier types for the
// sensing-setting parameter store.
// assumes one clock domain and a byte-wide command/response stream.
package sspa_pkg;

	localparam int SSPA_NPARAM = 41;
	localparam int SSPA_IDX_W = 6;
	localparam int SSPA_VAL_W = 12;

	// command framing
	localparam logic [7:0] SSPA_MRC = 8'h02;
	localparam logic [7:0] SSPA_SRC_READ = 8'h01;
	localparam logic [7:0] SSPA_SRC_WRITE = 8'h02;
	localparam logic [7:0] SSPA_ADDR_PFX = 8'hc0;
	localparam logic [7:0] SSPA_CNT_PFX = 8'h80;
	localparam logic [7:0] SSPA_CNT_ONE = 8'h01;
	localparam logic [3:0] SSPA_READ_LEN = 4'hc - 4'h4;
	localparam logic [3:0] SSPA_WRITE_LEN = 4'hc;
	localparam logic [3:0] SSPA_SHORT_RESP_LEN = 4'h4;
	localparam logic [3:0] SSPA_READ_RESP_LEN = 4'hc;

	// byte positions inside a command
	localparam int SSPA_POS_MRC = 0;
	localparam int SSPA_POS_SRC = 1;
	localparam int SSPA_POS_ADDR_HI = 2;
	localparam int SSPA_POS_DATA = 3;
	localparam int SSPA_POS_UNIT = 4;
	localparam int SSPA_POS_CHAN = 5;
	localparam int SSPA_POS_CNT_HI = 6;
	localparam int SSPA_POS_CNT_LO = 7;
	localparam int SSPA_POS_VAL = 8;

	// response words
	localparam logic [15:0] SSPA_RC_NORMAL = 16'h0000;
	localparam logic [15:0] SSPA_RC_LONG = 16'h1001;
	localparam logic [15:0] SSPA_RC_SHORT = 16'h1002;
	localparam logic [15:0] SSPA_RC_ADDR = 16'h1101;
	localparam logic [15:0] SSPA_RC_CHAN = 16'h1103;
	localparam logic [15:0] SSPA_RC_RANGE = 16'h2203;
	localparam logic [15:0] SSPA_RC_INVALID = 16'h2205;

	// units and codes that steer validity
	localparam logic [7:0] SSPA_UNIT_LIGHT = 8'h02;
	localparam logic [7:0] SSPA_UNIT_AREA1 = 8'h07;
	localparam logic [7:0] SSPA_UNIT_AREA2 = 8'h08;
	localparam logic [11:0] SSPA_MODE_CUSTOM = 12'h004;
	localparam logic [11:0] SSPA_OBJ_THICKNESS = 12'h004;
	localparam logic [11:0] SSPA_OBJ_GAP = 12'h005;
	localparam logic [11:0] SSPA_MAT_FILM = 12'h001;
	localparam logic [11:0] SSPA_GMODE_MOVING = 12'h001;
	localparam logic [11:0] SSPA_MIF_ON = 12'h001;

	// table indices read by the settings outputs
	localparam int SSPA_IDX_MODE = 0;
	localparam int SSPA_IDX_EXPOSURE_TIME_SETTING = 1;
	localparam int SSPA_IDX_LINE = 2;
	localparam int SSPA_IDX_SKIP = 3;
	localparam int SSPA_IDX_OBJECT = 13;
	localparam int SSPA_IDX_GLASS = 14;
	localparam int SSPA_IDX_GMODE = 15;
	localparam int SSPA_IDX_MIF = 20;
	localparam int SSPA_IDX_TIMING = 21;
	localparam int SSPA_IDX_GAIN = 22;

	// unit, data, lowest, highest; reset value is the lowest
	typedef struct packed {
		logic [7:0] unit;
		logic [7:0] data;
		logic [11:0] lo;
		logic [11:0] hi;
	} sspa_entry_t;

	typedef struct packed {
		logic [2:0] measurement_mode;
		logic custom_active;
		logic [7:0] exposure_time_setting;
		logic [7:0] line_count;
		logic skip;
		logic two_area_active;
		logic glass_material_eff;
		logic glass_mode_eff;
		logic interference_on;
		logic timing_b_eff;
		logic [2:0] gain;
	} sspa_settings_t;

	localparam sspa_entry_t SSPA_TABLE [SSPA_NPARAM] = '{
		'{8'h00, 8'h00, 12'h000, 12'h004}, // mode, see R05
		'{8'h00, 8'h12, 12'h002, 12'h0c8},
		'{8'h00, 8'h13, 12'h001, 12'h0c8},
		'{8'h00, 8'h14, 12'h000, 12'h001},
		'{8'h01, 8'h00, 12'h000, 12'h001},
		'{8'h02, 8'h00, 12'h000, 12'h002}, // see R12
		'{8'h02, 8'h02, 12'h000, 12'h003}, // see R12
		'{8'h02, 8'h06, 12'h000, 12'h3e8}, // see R14
		'{8'h02, 8'h0d, 12'h000, 12'h320}, // see R14
		'{8'h02, 8'h0e, 12'h000, 12'h320}, // see R14
		'{8'h02, 8'h25, 12'h000, 12'hfff},
		'{8'h02, 8'h26, 12'h000, 12'hfff},
		'{8'h02, 8'h27, 12'h000, 12'hfff},
		'{8'h03, 8'h00, 12'h000, 12'h005}, // see R06
		'{8'h03, 8'h01, 12'h000, 12'h001}, // see R07
		'{8'h03, 8'h02, 12'h000, 12'h001}, // see R08
		'{8'h03, 8'h03, 12'h000, 12'h004}, // see R09
		'{8'h03, 8'h04, 12'h000, 12'h0ff},
		'{8'h03, 8'h05, 12'h000, 12'hfff},
		'{8'h03, 8'h06, 12'h000, 12'h007}, // see R10
		'{8'h04, 8'h00, 12'h000, 12'h001}, // see R11
		'{8'h04, 8'h01, 12'h000, 12'h001}, // see R11
		'{8'h05, 8'h00, 12'h001, 12'h005}, // see R16
		'{8'h07, 8'h00, 12'h000, 12'h002},
		'{8'h07, 8'h02, 12'h000, 12'h003},
		'{8'h07, 8'h06, 12'h000, 12'h3e8},
		'{8'h07, 8'h0d, 12'h000, 12'h320},
		'{8'h07, 8'h0e, 12'h000, 12'h320},
		'{8'h07, 8'h11, 12'h000, 12'h002},
		'{8'h07, 8'h25, 12'h000, 12'hfff},
		'{8'h07, 8'h26, 12'h000, 12'hfff},
		'{8'h07, 8'h27, 12'h000, 12'hfff},
		'{8'h08, 8'h00, 12'h000, 12'h002},
		'{8'h08, 8'h02, 12'h000, 12'h003},
		'{8'h08, 8'h06, 12'h000, 12'h3e8},
		'{8'h08, 8'h0d, 12'h000, 12'h320},
		'{8'h08, 8'h0e, 12'h000, 12'h320},
		'{8'h08, 8'h11, 12'h000, 12'h002},
		'{8'h08, 8'h25, 12'h000, 12'hfff},
		'{8'h08, 8'h26, 12'h000, 12'hfff},
		'{8'h08, 8'h27, 12'h000, 12'hfff}
	};

endpackage

// File: rtl/sspa_core.sv
// sspa_core: command interpreter and store for sensing-setting parameters.
// assumes a byte stream from logic on the same clock, one frame per command,
// with rx_last on the final byte; replies go out on a byte stream with ready.
//
// Functional notes
// R01: read frame is 02h 01h, C000h+data, unit/channel, 8000h+count.
// R02: good read echoes all command words, then the 32-bit value.
// R03: write frame is 02h 02h, same three words, then 32-bit value.
// R04: good write answers code pair plus response word 0000h.
// R05: mode codes 0..4; exposure, line, skip matter only in custom.
// R06: measurement object codes 0 to 5.
// R07: glass material 0/1, effective only with thickness or gap object.
// R08: glass thickness mode 0/1, effective only with film material.
// R09: smoothing level codes 0 to 4.
// R10: edge threshold codes 0 to 7, 12.5 percent per step.
// R11: timing A/B effective only while interference prevention is on.
// R12: target area codes 0..3; emitted light setting codes 0..2.
// R13: two-area mode validates units 07h/08h and invalidates 02h.
// R14: light limits 0..800, fixed level 0..1000.
// R15: parameters found by unit and data; channel selects the controller.
// R16: gain at unit 05h data 00h, range 1 to 5.
// R17: values are 32-bit two's complement.
// R18: too long frame answers 1001h, too short 1002h, no access.
// R19: out-of-range write keeps stored value and answers an error.
// R20: read returns last good write, else the reset value.
module sspa_core
	import sspa_pkg::*;
(
	input wire logic clk, // 100 MHz
	input wire logic reset_n, // async, active low
	input wire logic [7:0] channel_id, // this controller's channel
	input wire logic [7:0] rx_data, // command byte
	input wire logic rx_valid, // command byte present
	input wire logic rx_last, // final byte of the frame
	output logic rx_ready, // accepting command bytes
	output logic [7:0] tx_data, // reply byte
	output logic tx_valid, // reply byte present
	output logic tx_last, // final reply byte
	input wire logic tx_ready, // reply sink accepts
	output sspa_settings_t settings // effective settings
);

	////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		S_RECV = 3'b001,
		S_EXEC = 3'b010,
		S_SEND = 3'b100
	} sspa_state_t;

	sspa_state_t state;
	sspa_state_t next_state;
	logic [7:0] cmd [SSPA_WRITE_LEN];
	logic [3:0] rx_count;
	logic cmd_long;
	logic [11:0] store [SSPA_NPARAM];
	logic [7:0] resp [SSPA_WRITE_LEN];
	logic [7:0] next_resp [SSPA_WRITE_LEN];
	logic [3:0] resp_len;
	logic [3:0] next_len;
	logic [3:0] tx_index;

	function automatic logic [SSPA_IDX_W:0] param_find(input logic [7:0] unit,
		input logic [7:0] data);
		logic [SSPA_IDX_W:0] r;
		r = '0;
		for (int i = 0; i < SSPA_NPARAM; i++) begin
			if (SSPA_TABLE[i].unit == unit && SSPA_TABLE[i].data == data) begin
				r = {1'b1, SSPA_IDX_W'(i)};
			end
		end
		return r;
	endfunction

	function automatic logic in_range(input logic [31:0] v, input logic [11:0] lo,
		input logic [11:0] hi);
		return ($signed(v) >= $signed({20'h00000, lo})) &&
			($signed(v) <= $signed({20'h00000, hi}));
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// frame decode
	wire rx_take = rx_valid && rx_ready;
	wire is_write = cmd[SSPA_POS_SRC] == SSPA_SRC_WRITE;
	wire code_ok = cmd[SSPA_POS_MRC] == SSPA_MRC &&
		(cmd[SSPA_POS_SRC] == SSPA_SRC_READ || is_write); // see R01 R03
	wire [3:0] exp_len = is_write ? SSPA_WRITE_LEN : SSPA_READ_LEN;
	wire [7:0] unit = cmd[SSPA_POS_UNIT];
	wire addr_ok = cmd[SSPA_POS_ADDR_HI] == SSPA_ADDR_PFX &&
		cmd[SSPA_POS_CNT_HI] == SSPA_CNT_PFX && cmd[SSPA_POS_CNT_LO] == SSPA_CNT_ONE;
	wire [SSPA_IDX_W:0] found = param_find(unit, cmd[SSPA_POS_DATA]); // see R15
	wire hit = found[SSPA_IDX_W];
	wire [SSPA_IDX_W-1:0] idx = found[SSPA_IDX_W-1:0];
	wire [31:0] wr_value = {cmd[SSPA_POS_VAL], cmd[SSPA_POS_VAL+1],
		cmd[SSPA_POS_VAL+2], cmd[SSPA_POS_VAL+3]}; // see R17
	wire [11:0] sel_value = store[idx];
	wire [31:0] rd_value = {20'h00000, sel_value}; // see R17 R20
	wire range_ok = in_range(wr_value, SSPA_TABLE[idx].lo, SSPA_TABLE[idx].hi);

	wire two_area = (store[SSPA_IDX_OBJECT] == SSPA_OBJ_THICKNESS ||
		store[SSPA_IDX_OBJECT] == SSPA_OBJ_GAP) &&
		store[SSPA_IDX_GLASS] == SSPA_MAT_FILM &&
		store[SSPA_IDX_GMODE] == SSPA_GMODE_MOVING;
	wire area_unit = unit == SSPA_UNIT_AREA1 || unit == SSPA_UNIT_AREA2;
	wire unit_gated = (unit == SSPA_UNIT_LIGHT && two_area) ||
		(area_unit && !two_area); // see R13

	logic [15:0] rc;
	always_comb begin
		if (rx_count < 4'h2) begin
			rc = SSPA_RC_SHORT; // see R18
		end else if (!code_ok) begin
			rc = SSPA_RC_INVALID;
		end else if (cmd_long || rx_count > exp_len) begin
			rc = SSPA_RC_LONG; // see R18
		end else if (rx_count < exp_len) begin
			rc = SSPA_RC_SHORT; // see R18
		end else if (!addr_ok || !hit) begin
			rc = SSPA_RC_ADDR;
		end else if (cmd[SSPA_POS_CHAN] != channel_id) begin
			rc = SSPA_RC_CHAN; // see R15
		end else if (unit_gated) begin
			rc = SSPA_RC_INVALID;
		end else if (is_write && !range_ok) begin
			rc = SSPA_RC_RANGE; // see R19 R05 R06 R09 R10 R12 R14 R16
		end else begin
			rc = SSPA_RC_NORMAL;
		end
	end

	wire good = rc == SSPA_RC_NORMAL;
	wire do_write = state == S_EXEC && is_write && good; // see R03
	wire read_reply = !is_write && good;

	////////////////////////////////////////////////////////////////////////////
	// reply build
	always_comb begin
		for (int i = 0; i < SSPA_WRITE_LEN; i++) begin
			next_resp[i] = 8'h00;
		end
		next_resp[0] = cmd[SSPA_POS_MRC];
		next_resp[1] = cmd[SSPA_POS_SRC];
		if (read_reply) begin
			for (int i = SSPA_POS_ADDR_HI; i < SSPA_POS_VAL; i++) begin
				next_resp[i] = cmd[i]; // see R02
			end
			next_resp[SSPA_POS_VAL] = rd_value[31:24];
			next_resp[SSPA_POS_VAL+1] = rd_value[23:16];
			next_resp[SSPA_POS_VAL+2] = rd_value[15:8];
			next_resp[SSPA_POS_VAL+3] = rd_value[7:0];
			next_len = SSPA_READ_RESP_LEN;
		end else begin
			next_resp[2] = rc[15:8]; // see R04 R18 R19
			next_resp[3] = rc[7:0];
			next_len = SSPA_SHORT_RESP_LEN;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// sequencing
	always_comb begin
		case (state)
			S_RECV: next_state = (rx_take && rx_last) ? S_EXEC : S_RECV;
			S_EXEC: next_state = S_SEND;
			S_SEND: next_state = (tx_valid && tx_ready && tx_last) ? S_RECV : S_SEND;
			default: next_state = S_RECV;
		endcase
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			state <= S_RECV;
			rx_ready <= 1'b1;
		end else begin
			state <= next_state;
			rx_ready <= next_state == S_RECV;
		end
	end

	// receive counter; a new frame starts after each reply
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_count <= 4'h0;
			cmd_long <= 1'b0;
		end else if (state == S_SEND) begin
			rx_count <= 4'h0;
			cmd_long <= 1'b0;
		end else if (rx_take) begin
			if (rx_count == SSPA_WRITE_LEN) begin
				cmd_long <= 1'b1; // see R18
			end else begin
				rx_count <= rx_count + 4'h1;
			end
		end
	end

	generate
		for (genvar g = 0; g < SSPA_WRITE_LEN; g++) begin : g_cmd
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					cmd[g] <= 8'h00;
				end else if (rx_take && rx_count == 4'(g)) begin
					cmd[g] <= rx_data;
				end
			end
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					resp[g] <= 8'h00;
				end else if (state == S_EXEC) begin
					resp[g] <= next_resp[g];
				end
			end
		end
		for (genvar p = 0; p < SSPA_NPARAM; p++) begin : g_store
			always_ff @(posedge clk or negedge reset_n) begin
				if (!reset_n) begin
					store[p] <= SSPA_TABLE[p].lo; // see R20
				end else if (do_write && idx == SSPA_IDX_W'(p)) begin
					store[p] <= wr_value[11:0]; // see R19 R20
				end
			end
		end
	endgenerate

	// transmit
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			tx_data <= 8'h00;
			tx_valid <= 1'b0;
			tx_last <= 1'b0;
			tx_index <= 4'h0;
			resp_len <= 4'h0;
		end else if (state == S_EXEC) begin
			tx_data <= next_resp[0];
			tx_valid <= 1'b1;
			tx_last <= 1'b0;
			tx_index <= 4'h1;
			resp_len <= next_len;
		end else if (tx_valid && tx_ready) begin
			tx_valid <= !tx_last;
			tx_data <= tx_last ? 8'h00 : resp[tx_index];
			tx_last <= tx_index == resp_len - 4'h1;
			tx_index <= tx_index + 4'h1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// effective settings
	sspa_settings_t next_settings;
	wire custom = store[SSPA_IDX_MODE] == SSPA_MODE_CUSTOM;
	wire thick_gap = store[SSPA_IDX_OBJECT] == SSPA_OBJ_THICKNESS ||
		store[SSPA_IDX_OBJECT] == SSPA_OBJ_GAP;
	wire mat_eff = thick_gap && store[SSPA_IDX_GLASS] == SSPA_MAT_FILM; // see R07
	wire mif = store[SSPA_IDX_MIF] == SSPA_MIF_ON;

	always_comb begin
		next_settings.measurement_mode = store[SSPA_IDX_MODE][2:0];
		next_settings.custom_active = custom; // see R05
		next_settings.exposure_time_setting = custom ? store[SSPA_IDX_EXPOSURE_TIME_SETTING][7:0] : 8'h00;
		next_settings.line_count = custom ? store[SSPA_IDX_LINE][7:0] : 8'h00;
		next_settings.skip = custom && !store[SSPA_IDX_SKIP][0]; // skip code 0 means on
		next_settings.two_area_active = two_area; // see R13
		next_settings.glass_material_eff = mat_eff;
		next_settings.glass_mode_eff = mat_eff && store[SSPA_IDX_GMODE][0]; // see R08
		next_settings.interference_on = mif;
		next_settings.timing_b_eff = mif && store[SSPA_IDX_TIMING][0]; // see R11
		next_settings.gain = store[SSPA_IDX_GAIN][2:0];
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			// reset store seen through the gates: only gain is non-zero
			settings <= '{gain: SSPA_TABLE[SSPA_IDX_GAIN].lo[2:0], default: '0}; // see R16 R20
		end else begin
			settings <= next_settings;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_frame_to_reply: assert property ( // see R02
		rx_take && rx_last |-> ##2 tx_valid && tx_data == $past(next_resp[0], 1))
		else $error("reply did not start two cycles after frame end");
	a_write_ok_word: assert property ( // see R04
		state == S_EXEC && is_write && good |-> next_len == SSPA_SHORT_RESP_LEN &&
		next_resp[2] == 8'h00 && next_resp[3] == 8'h00)
		else $error("write completion word wrong");
	a_read_echo_len: assert property ( // see R02
		state == S_EXEC && !is_write && good |=> resp_len == SSPA_READ_RESP_LEN &&
		resp[SSPA_POS_CNT_LO] == SSPA_CNT_ONE)
		else $error("read reply length or echo wrong");
	a_bad_write_keeps: assert property ( // see R19
		state == S_EXEC && is_write && rc == SSPA_RC_RANGE |=> $stable(sel_value))
		else $error("rejected write changed the store");
	a_write_commits: assert property ( // see R20
		do_write |=> sel_value == $past(wr_value[11:0]))
		else $error("good write not stored");
	a_long_error: assert property ( // see R18
		state == S_EXEC && code_ok && cmd_long |-> rc == SSPA_RC_LONG)
		else $error("long frame not answered 1001h");
	a_short_error: assert property ( // see R18
		state == S_EXEC && rx_count < 4'h2 |-> rc == SSPA_RC_SHORT)
		else $error("short frame not answered 1002h");
	a_gain_range: assert property ( // see R16
		settings.gain >= 3'h1 && settings.gain <= 3'h5)
		else $error("gain out of 1..5");
	a_area_gate: assert property ( // see R13
		state == S_EXEC && area_unit && !two_area |-> !good)
		else $error("area unit accepted outside two-area mode");
	a_glass_chain: assert property ( // see R07 R08
		settings.glass_mode_eff |-> settings.glass_material_eff)
		else $error("glass mode effective without film material");
	a_timing_gate: assert property ( // see R11
		$rose(settings.timing_b_eff) |-> $past(mif) && settings.interference_on)
		else $error("timing B effective with interference off");
	a_reply_ends: assert property ( // see R02 R04
		tx_valid && tx_ready && tx_last |=> !tx_valid ##1 rx_ready)
		else $error("reply did not end cleanly");

	c_read_ok: cover property (state == S_EXEC && !is_write && good);
	c_write_ok: cover property (state == S_EXEC && is_write && good);
	c_long: cover property (state == S_EXEC && rc == SSPA_RC_LONG);
	c_range: cover property (state == S_EXEC && rc == SSPA_RC_RANGE);

endmodule

// File: testbench/sspa_host_model.sv
// sspa_host_model: host side that sends command frames and takes replies.
// assumes its tasks are called at a falling clock edge.
module sspa_host_model (
	input wire logic clk, // bench clock
	output logic [7:0] rx_data, // command byte
	output logic rx_valid, // byte present
	output logic rx_last, // final byte
	input wire logic rx_ready, // store accepts
	input wire logic [7:0] tx_data, // reply byte
	input wire logic tx_valid, // reply present
	input wire logic tx_last, // final reply byte
	output logic tx_ready // host accepts
);
	timeunit 1ns;
	timeprecision 100ps;

	initial begin
		rx_data = 8'h00;
		rx_valid = 1'b0;
		rx_last = 1'b0;
		tx_ready = 1'b0;
	end

	////////////////////////////////////////
	// bytes held until taken; idle data toggles so stale values never match
	task automatic send_frame(input logic [7:0] f[$], input logic [31:0] gap);
		foreach (f[i]) begin
			if (gap[i]) begin
				rx_valid = 1'b0;
				rx_data = ~rx_data;
				@(negedge clk);
			end
			rx_data = f[i];
			rx_valid = 1'b1;
			rx_last = i == f.size() - 1;
			while (rx_ready !== 1'b1) @(negedge clk);
			@(negedge clk);
		end
		rx_valid = 1'b0;
		rx_last = 1'b0;
		rx_data = ~rx_data;
	endtask

	// reply sink with stalls; a byte counts when valid and ready meet
	task automatic get_reply(output logic [7:0] r[$], input logic [31:0] hold);
		logic done;
		r = {};
		done = 1'b0;
		for (int k = 0; k < 400 && !done; k++) begin
			tx_ready = !hold[k % 32] || k % 4 == 3;
			if (tx_valid === 1'b1 && tx_ready) begin
				r.push_back(tx_data);
				done = tx_last;
			end
			@(negedge clk);
		end
		tx_ready = 1'b0;
	endtask
endmodule

// File: testbench/test_sspa_core.sv
// test_sspa_core: self-checking bench for the sensing-setting store.
// assumes sspa_host_model as host; expectations come from a store model.
module test_sspa_core
	import sspa_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;

	typedef logic [7:0] sspa_tb_q_t[$];
	logic clk = 1'b0;
	logic reset_n;
	logic [7:0] channel_id;
	logic [7:0] rx_data;
	logic [7:0] tx_data;
	logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
	sspa_settings_t settings;
	logic [11:0] mstore[SSPA_NPARAM];
	logic [31:0] seed = 32'h0001_811f;
	int code_ix[8] = '{0, 16, 19, 5, 6, 21, 20, 13};
	int errors = 0;
	int checks = 0;
	int cycles = 0;

	always #5 clk = ~clk;

	sspa_core sspa_core_i (.clk(clk), .reset_n(reset_n), .channel_id(channel_id),
		.rx_data(rx_data), .rx_valid(rx_valid), .rx_last(rx_last), .rx_ready(rx_ready),
		.tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
		.settings(settings));
	sspa_host_model sspa_host_model_i (.clk(clk), .rx_data(rx_data), .rx_valid(rx_valid),
		.rx_last(rx_last), .rx_ready(rx_ready), .tx_data(tx_data), .tx_valid(tx_valid),
		.tx_last(tx_last), .tx_ready(tx_ready));

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			errors = errors + 1;
			stop_test();
		end
	end

	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	function automatic sspa_tb_q_t mk(input logic wr, input logic [7:0] u, d, ch,
		input logic [31:0] v);
		sspa_tb_q_t q;
		q = {SSPA_MRC, wr ? SSPA_SRC_WRITE : SSPA_SRC_READ, SSPA_ADDR_PFX, d, u, ch,
			SSPA_CNT_PFX, SSPA_CNT_ONE};
		if (wr) q = {q, v[31:24], v[23:16], v[15:8], v[7:0]};
		return q;
	endfunction

	function automatic sspa_tb_q_t rdq(input int ix);
		return mk(1'b0, SSPA_TABLE[ix].unit, SSPA_TABLE[ix].data, 8'h00, 32'h0);
	endfunction

	function automatic sspa_tb_q_t wrq(input int ix, input logic [31:0] v);
		return mk(1'b1, SSPA_TABLE[ix].unit, SSPA_TABLE[ix].data, 8'h00, v);
	endfunction

	function automatic logic [103:0] pack(input sspa_tb_q_t q);
		logic [103:0] v;
		v = '0;
		foreach (q[i]) v = {v[95:0], q[i]};
		v[103:96] = 8'(q.size());
		return v;
	endfunction

	function automatic sspa_settings_t exp_set();
		sspa_settings_t s;
		logic cust;
		cust = mstore[SSPA_IDX_MODE] == SSPA_MODE_CUSTOM;
		s.measurement_mode = mstore[SSPA_IDX_MODE][2:0];
		s.custom_active = cust;
		s.exposure_time_setting = cust ? mstore[SSPA_IDX_EXPOSURE_TIME_SETTING][7:0] : 8'h00;
		s.line_count = cust ? mstore[SSPA_IDX_LINE][7:0] : 8'h00;
		s.skip = cust & !mstore[SSPA_IDX_SKIP][0];
		s.glass_material_eff = (mstore[SSPA_IDX_OBJECT] == SSPA_OBJ_THICKNESS
			|| mstore[SSPA_IDX_OBJECT] == SSPA_OBJ_GAP) && mstore[SSPA_IDX_GLASS] == SSPA_MAT_FILM;
		s.glass_mode_eff = s.glass_material_eff && mstore[SSPA_IDX_GMODE] == SSPA_GMODE_MOVING;
		s.two_area_active = s.glass_mode_eff;
		s.interference_on = mstore[SSPA_IDX_MIF] == SSPA_MIF_ON;
		s.timing_b_eff = s.interference_on && mstore[SSPA_IDX_TIMING] == 12'h001;
		s.gain = mstore[SSPA_IDX_GAIN][2:0];
		return s;
	endfunction

	// expected reply; a good write also updates the store model
	task automatic predict(input sspa_tb_q_t f, output sspa_tb_q_t r);
		logic [15:0] rc;
		logic [31:0] v;
		logic wr;
		int n, ix;
		sspa_settings_t s;
		s = exp_set();
		n = f.size();
		wr = f[1] == SSPA_SRC_WRITE;
		ix = -1;
		foreach (SSPA_TABLE[i]) if (SSPA_TABLE[i].unit == f[4] && SSPA_TABLE[i].data == f[3]) ix = i;
		v = n > 11 ? {f[8], f[9], f[10], f[11]} : 32'h0;
		rc = SSPA_RC_NORMAL;
		if (f[0] != SSPA_MRC || !(f[1] == SSPA_SRC_READ || wr)) rc = SSPA_RC_INVALID;
		else if (n > (wr ? 12 : 8)) rc = SSPA_RC_LONG;
		else if (n < (wr ? 12 : 8)) rc = SSPA_RC_SHORT;
		else if (f[2] != SSPA_ADDR_PFX || f[6] != SSPA_CNT_PFX || f[7] != SSPA_CNT_ONE || ix < 0)
			rc = SSPA_RC_ADDR;
		else if (f[5] != channel_id) rc = SSPA_RC_CHAN;
		else if (s.two_area_active ? f[4] == SSPA_UNIT_LIGHT
			: (f[4] == SSPA_UNIT_AREA1 || f[4] == SSPA_UNIT_AREA2)) rc = SSPA_RC_INVALID;
		else if (wr && v > 32'(SSPA_TABLE[ix].hi) || wr && v < 32'(SSPA_TABLE[ix].lo))
			rc = SSPA_RC_RANGE;
		r = {f[0], f[1]};
		if (rc == SSPA_RC_NORMAL && !wr) begin
			for (int i = 2; i < 8; i++) r.push_back(f[i]);
			v = 32'(mstore[ix]);
			r = {r, v[31:24], v[23:16], v[15:8], v[7:0]};
		end else begin
			if (rc == SSPA_RC_NORMAL) mstore[ix] = v[11:0];
			r = {r, rc[15:8], rc[7:0]};
		end
	endtask

	////////////////////////////////////////
	task automatic check_reply(input logic [103:0] e, input logic [103:0] g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected reply: expected %h, seen %h", e, g);
		end
	endtask

	task automatic check_set(input sspa_settings_t e, input sspa_settings_t g);
		checks++;
		if (g !== e) begin
			errors++;
			$display("unexpected settings: expected %h, seen %h", e, g);
		end
	endtask

	task automatic do_cmd(input sspa_tb_q_t f);
		sspa_tb_q_t e, g;
		predict(f, e);
		sspa_host_model_i.send_frame(f, rnd() & rnd());
		sspa_host_model_i.get_reply(g, rnd());
		check_reply(pack(e), pack(g));
		check_set(exp_set(), settings);
	endtask

	task automatic stop_test();
		if (errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	////////////////////////////////////////
	initial begin
		sspa_tb_q_t f;
		int ix;
		logic [11:0] hi;
		channel_id = 8'h00;
		reset_n = 1'b0;
		foreach (mstore[i]) mstore[i] = SSPA_TABLE[i].lo;
		repeat (3) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		check_set(exp_set(), settings);
		foreach (SSPA_TABLE[i]) do_cmd(rdq(i));
		channel_id = 8'h01;
		do_cmd(mk(1'b1, 8'h03, 8'h06, 8'h01, 32'h4));
		do_cmd(mk(1'b0, 8'h03, 8'h06, 8'h01, 32'h0));
		do_cmd(mk(1'b0, 8'h03, 8'h06, 8'h00, 32'h0));
		channel_id = 8'h00;
		foreach (SSPA_TABLE[i]) begin
			hi = SSPA_TABLE[i].hi;
			do_cmd(wrq(i, 32'(hi) + 1));
			do_cmd(wrq(i, 32'(hi)));
			do_cmd(rdq(i));
		end
		do_cmd(wrq(SSPA_IDX_OBJECT, 32'h0));
		foreach (code_ix[j]) begin
			for (int c = 0; c < 9; c++) do_cmd(wrq(code_ix[j], c));
		end
		do_cmd(rdq(23));
		do_cmd(rdq(5));
		f = rdq(SSPA_IDX_GAIN);
		f.push_back(8'h00);
		do_cmd(f);
		f = wrq(SSPA_IDX_GAIN, 32'h3);
		f.push_back(8'h3c);
		do_cmd(f);
		f = wrq(SSPA_IDX_GAIN, 32'h2);
		void'(f.pop_back());
		do_cmd(f);
		f = rdq(SSPA_IDX_GAIN);
		void'(f.pop_back());
		do_cmd(f);
		f[1] = 8'h03;
		f.push_back(8'h01);
		do_cmd(f);
		f[1] = SSPA_SRC_READ;
		f[7] = 8'h02;
		do_cmd(f);
		do_cmd(mk(1'b0, 8'h06, 8'h00, 8'h00, 32'h0));
		do_cmd(wrq(SSPA_IDX_GAIN, 32'hffff_fffe));
		do_cmd(wrq(SSPA_IDX_GAIN, 32'h0));
		repeat (300) begin
			ix = rnd() % SSPA_NPARAM;
			hi = SSPA_TABLE[ix].hi;
			if (rnd() % 3 == 0) do_cmd(rdq(ix));
			else do_cmd(wrq(ix, rnd() % (32'(hi) + 3)));
		end
		stop_test();
	end
endmodule
